// file: test/prbm_dac_tb.sv
// Self-checking bench for the pulse DAC: APB register access and filtered levels.
// Assumes the design answers each APB access one cycle after setup.
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin num_errors++; \
   $display("unexpected %s expected %h seen %h", n, e, g); end end
module prbm_dac_tb;
   logic        clk;
   logic        rst_b;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic        pready;
   logic [31:0] prdata;
   logic        pslverr;
   logic [1:0]  dacOut;
   int          charge0;
   int          charge1;
   int          num_errors = 0;
   int          comparisons = 0;
   int          cycles = 0;
   logic [31:0] rd;
   logic        err;

   prbm_dac prbm_dac_inst (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
      .prdata(prdata), .pslverr(pslverr), .dacOut(dacOut));
   prbm_rc_filter prbm_rc_filter_inst (.clk(clk), .pin(dacOut), .charge0(charge0),
      .charge1(charge1));

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   task automatic test_done;
      $display("checks %0d mismatches %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   always @(posedge clk) begin
      cycles++;
      if (cycles == 30000) begin
         num_errors++;
         test_done();
      end
   end

   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd  = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic t_regs;
      apb(1'b0, `PRBM_OFS_WEIGHT0, 32'h0);
      `CHK("weight0 reset", 32'h0000_0080, rd)
      apb(1'b0, `PRBM_OFS_FINE, 32'h0);
      `CHK("fine reset", 32'h0000_0000, rd)
      apb(1'b0, `PRBM_OFS_WEIGHT1, 32'h0);
      `CHK("weight1 reset", 32'h0000_0080, rd)
      apb(1'b1, `PRBM_OFS_WEIGHT1, 32'h0000_0015);
      apb(1'b0, `PRBM_OFS_WEIGHT1, 32'h0);
      `CHK("weight bit 7", 32'h0000_0095, rd)
      apb(1'b1, `PRBM_OFS_FINE, 32'h0000_00a5);
      apb(1'b0, `PRBM_OFS_FINE, 32'h0);
      `CHK("fine readback", 32'h0000_00a5, rd)
      apb(1'b0, 12'h00c, 32'h0);
      `CHK("unmapped error", 1'b1, err)
      `CHK("unmapped data", 32'h0000_0000, rd)
   endtask

   // Levels are checked only after a whole frame has passed with the new values.
   task automatic t_level(input logic [7:0] w0, w1, f, input int e0, e1);
      apb(1'b1, `PRBM_OFS_WEIGHT0, {24'h0, w0});
      apb(1'b1, `PRBM_OFS_WEIGHT1, {24'h0, w1});
      apb(1'b1, `PRBM_OFS_FINE, {24'h0, f});
      repeat (1100) @(posedge clk);
      `CHK("level ch0", e0, charge0)
      `CHK("level ch1", e1, charge1)
   endtask

   initial begin
      rst_b   = 1'b0;
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = 12'h000;
      pwdata  = 32'h0;
      repeat (5) @(posedge clk);
      `CHK("reset outputs", 2'h0, dacOut)
      rst_b <= 1'b1;
      t_regs();
      t_level(8'h00, 8'h40, 8'h00, 0, 1024);
      t_level(8'h3f, 8'h18, 8'h6f, 1023, 390);
      t_level(8'h10, 8'h10, 8'h21, 257, 258);
      t_level(8'h10, 8'h10, 8'h84, 260, 264);
      t_level(8'h50, 8'h20, 8'h00, 768, 512);
      test_done();
   end
endmodule
`default_nettype wire

// file: test/prbm_rc_filter.sv
// Behavioural RC low-pass model for both DAC pins: charge is the pin's high time.
// Assumes a window of 1024 clocks, one whole fine-step frame.
`timescale 1ns/10ps
`default_nettype none
module prbm_rc_filter (
   input  wire logic       clk,
   input  wire logic [1:0] pin,
   output int              charge0,
   output int              charge1
);
   logic [1023:0] hist0 = '0;
   logic [1023:0] hist1 = '0;
   // A full frame window makes the level independent of where the frame starts.
   always_ff @(posedge clk) begin
      hist0 <= {hist0[1022:0], pin[0]};
      hist1 <= {hist1[1022:0], pin[1]};
   end
   assign charge0 = $countones(hist0);
   assign charge1 = $countones(hist1);
endmodule
`default_nettype wire

// file: verilog/prbm_dac.sv
// Two-channel pulse-width plus rate-multiplier DAC with an APB register slave.
// Assumes one clock, an asynchronous active-low reset and external RC filters on the outputs.
//
// Decided for this implementation: the address map and the APB slave port.
`timescale 1ns/10ps
`default_nettype none
`include "prbm_defines.svh"

// Summary of operation
// - Ten-bit value splits into six-bit weight and four-bit fine field, one shared counter.
// - Shared counter increments every clock and wraps freely.
// - When low six counter bits wrap to zero, channels with nonzero weight go active.
// - Pulse counter equal to weight returns output inactive for the cycle.
// - Invert bit 0 means high during pulse; 1 means low during pulse.
// - Selected cycles get one extra clock at the pulse start.
// - Fine bits select cycle 8; 4,12; 2,6,10,14; odd cycles; union.
// - Frame cycle zero never gets an extra pulse.
// - Weight 3Fh, fine 0Fh: active cycles 1-15, one inactive clock at count 63 of cycle 15, just ahead of cycle 0.
// - Weight and fine zero keep the output inactive.
// - Zero weight and fine with invert set hold the output high.
// - After reset the outputs are driven low.
// - Weight register bit 7 reads one, bit 6 invert, bits 5:0 weight, reset 80h.
// - Fine register bits 7:4 serve channel 1, bits 3:0 channel 0, reset zero.
module prbm_dac #(
   parameter int CHANNELS = 2
) (
   input  wire logic        clk,
   input  wire logic        rst_b,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic [31:0]      prdata,
   output logic             pslverr,
   output logic [1:0]       dacOut
);

   logic [`PRBM_CNT_W-1:0]   counter;
   logic [`PRBM_CNT_W-1:0]   next_counter;
   prbm_pkg::prbm_chan_s     chan [CHANNELS];
   prbm_pkg::prbm_chan_s     next_chan [CHANNELS];
   logic [7:0]               fine;
   logic [7:0]               next_fine;
   prbm_pkg::prbm_bus_e      busState;
   prbm_pkg::prbm_bus_e      next_busState;
   logic                     next_pready;
   logic [31:0]              next_prdata;
   logic                     next_pslverr;
   logic [1:0]               next_dacOut;
   logic [CHANNELS-1:0]      active;
   logic [CHANNELS-1:0]      next_active;

   wire logic [5:0] pulseCnt = counter[5:0];
   wire logic [3:0] frameCyc = counter[9:6];

   // Maps the frame cycle number to the fine bit that selects it.
   function automatic logic fine_hit(input logic [3:0] cyc, input logic [3:0] bits);
      logic hit;
      hit = 1'b0;
      if (cyc[0]) begin
         hit = bits[3];
      end else if (cyc[1:0] == 2'b10) begin
         hit = bits[2];
      end else if (cyc[2:0] == 3'b100) begin
         hit = bits[1];
      end else if (cyc == 4'h8) begin
         hit = bits[0];
      end
      return hit;
   endfunction

   function automatic logic [7:0] weight_read(input prbm_pkg::prbm_chan_s c);
      return `PRBM_WEIGHT_FIXED | {1'b0, c};
   endfunction

   // True for the three mapped word offsets; anything else answers with an error.
   function automatic logic reg_hit(input logic [11:0] a);
      return (a == `PRBM_OFS_WEIGHT0) || (a == `PRBM_OFS_WEIGHT1) || (a == `PRBM_OFS_FINE);
   endfunction

   // The counter never stops; wrap is natural width overflow.
   always_comb begin
      next_counter = counter + 10'h001;
   end

   // Each channel: the extra clock is count 63 of the cycle before, so it leads the
   // pulse that follows. It wins over a weight match on that same count.
   generate
      for (genvar i = 0; i < CHANNELS; i++) begin : g_chan
         wire logic [3:0] nextCyc = next_counter[9:6] + 4'h1;
         wire logic [3:0] chanFine = fine[4*i +: 4];
         always_comb begin
            next_active[i] = active[i];
            if (next_counter[5:0] == 6'h3f && fine_hit(nextCyc, chanFine)) begin
               next_active[i] = 1'b1;
            end else if (next_counter[5:0] == 6'h00) begin
               next_active[i] = (chan[i].weight != 6'h00);
            end else if (next_counter[5:0] == chan[i].weight) begin
               next_active[i] = 1'b0;
            end
            next_dacOut[i] = next_active[i] ^ chan[i].invert;
         end
      end
   endgenerate

   // APB slave: one wait-free access phase, writes take effect on the completing edge.
   always_comb begin
      next_busState = busState;
      next_pready   = 1'b0;
      next_prdata   = prdata;
      next_pslverr  = 1'b0;
      next_fine     = fine;
      for (int k = 0; k < CHANNELS; k++) begin
         next_chan[k] = chan[k];
      end
      case (busState)
         prbm_pkg::PRBM_IDLE: begin
            if (psel && !penable) begin
               next_busState = prbm_pkg::PRBM_ACCESS;
               next_pready   = 1'b1;
               next_prdata   = 32'h0000_0000;
               case (paddr)
                  `PRBM_OFS_WEIGHT0: begin
                     next_prdata = {24'h00_0000, weight_read(chan[0])};
                  end
                  `PRBM_OFS_WEIGHT1: begin
                     next_prdata = {24'h00_0000, weight_read(chan[1])};
                  end
                  `PRBM_OFS_FINE: begin
                     next_prdata = {24'h00_0000, fine};
                  end
                  default: begin
                     next_pslverr = 1'b1;
                  end
               endcase
            end
         end
         prbm_pkg::PRBM_ACCESS: begin
            next_busState = prbm_pkg::PRBM_IDLE;
            if (pwrite) begin
               case (paddr)
                  `PRBM_OFS_WEIGHT0: begin
                     next_chan[0] = pwdata[6:0];
                  end
                  `PRBM_OFS_WEIGHT1: begin
                     next_chan[1] = pwdata[6:0];
                  end
                  `PRBM_OFS_FINE: begin
                     next_fine = pwdata[7:0];
                  end
                  default: begin
                     next_fine = fine;
                  end
               endcase
            end
         end
         default: begin
            next_busState = prbm_pkg::PRBM_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         counter  <= 10'h000;
         fine     <= `PRBM_FINE_RST;
         busState <= prbm_pkg::PRBM_IDLE;
         pready   <= 1'b0;
         prdata   <= 32'h0000_0000;
         pslverr  <= 1'b0;
         active   <= '0;
         dacOut   <= 2'b00;
         for (int k = 0; k < CHANNELS; k++) begin
            chan[k] <= 7'h00;
         end
      end else begin
         counter  <= next_counter;
         fine     <= next_fine;
         busState <= next_busState;
         pready   <= next_pready;
         prdata   <= next_prdata;
         pslverr  <= next_pslverr;
         active   <= next_active;
         dacOut   <= next_dacOut;
         for (int k = 0; k < CHANNELS; k++) begin
            chan[k] <= next_chan[k];
         end
      end
   end

   AST_CNT_STEP: assert property (@(posedge clk) disable iff (!rst_b)
      counter == $past(counter) + 10'h001 || !$past(rst_b)) else $error("counter skipped");
   AST_WRAP_ON: assert property (@(posedge clk) disable iff (!rst_b)
      (pulseCnt == 6'h00 && chan[0].weight != 6'h00 && $stable(chan[0]))
      |-> active[0]) else $error("channel 0 not active at wrap");
   AST_MATCH_OFF: assert property (@(posedge clk) disable iff (!rst_b)
      (pulseCnt == chan[0].weight && pulseCnt != 6'h3f && pulseCnt != 6'h00 && $stable(chan[0]))
      |-> !active[0]) else $error("channel 0 active past weight");
   AST_POLARITY: assert property (@(posedge clk) disable iff (!rst_b)
      $stable(chan[0]) |-> dacOut[0] == (active[0] ^ chan[0].invert))
      else $error("output polarity wrong");
   AST_ZERO_LOW: assert property (@(posedge clk) disable iff (!rst_b)
      (chan[0] == 7'h00 && fine[3:0] == 4'h0) [*2] |-> dacOut[0] == 1'b0)
      else $error("zero channel not low");
   AST_ZERO_HIGH: assert property (@(posedge clk) disable iff (!rst_b)
      (chan[1] == 7'h40 && fine[7:4] == 4'h0) [*2] |-> dacOut[1] == 1'b1)
      else $error("static high not held");
   AST_FRAME0_NOADD: assert property (@(posedge clk) disable iff (!rst_b)
      (counter == 10'h3ff && $stable(chan[0]) && chan[0].weight == 6'h00 && $stable(fine))
      |=> !active[0]) else $error("extra pulse in cycle zero");
   AST_FIXED_BIT: assert property (@(posedge clk) disable iff (!rst_b)
      (busState == prbm_pkg::PRBM_ACCESS && !pslverr && $past(paddr) != `PRBM_OFS_FINE)
      |-> prdata[7] == 1'b1) else $error("weight bit 7 not one");
   AST_ONE_WAIT: assert property (@(posedge clk) disable iff (!rst_b)
      (psel && !penable && busState == prbm_pkg::PRBM_IDLE) |=> pready)
      else $error("no ready after setup");

   // Channel 1 mirrors the channel 0 checks above; AST_ZERO_HIGH0 mirrors the channel 1 static-high check.
   AST_WRAP_ON1: assert property (@(posedge clk) disable iff (!rst_b)
      (pulseCnt == 6'h00 && chan[1].weight != 6'h00 && $stable(chan[1]))
      |-> active[1]) else $error("channel 1 not active at wrap");
   AST_MATCH_OFF1: assert property (@(posedge clk) disable iff (!rst_b)
      (pulseCnt == chan[1].weight && pulseCnt != 6'h3f && pulseCnt != 6'h00 && $stable(chan[1]))
      |-> !active[1]) else $error("channel 1 active past weight");
   AST_POLARITY1: assert property (@(posedge clk) disable iff (!rst_b)
      $stable(chan[1]) |-> dacOut[1] == (active[1] ^ chan[1].invert))
      else $error("output polarity wrong on channel 1");
   AST_FRAME0_NOADD1: assert property (@(posedge clk) disable iff (!rst_b)
      (counter == 10'h3ff && $stable(chan[1]) && chan[1].weight == 6'h00 && $stable(fine))
      |=> !active[1]) else $error("extra pulse in cycle zero on channel 1");
   AST_ZERO_LOW1: assert property (@(posedge clk) disable iff (!rst_b)
      (chan[1] == 7'h00 && fine[7:4] == 4'h0) [*2] |-> dacOut[1] == 1'b0)
      else $error("zero channel 1 not low");
   AST_ZERO_HIGH0: assert property (@(posedge clk) disable iff (!rst_b)
      (chan[0] == 7'h40 && fine[3:0] == 4'h0) [*2] |-> dacOut[0] == 1'b1)
      else $error("static high not held on channel 0");

   // The extra clock sits on count 63 ahead of each selected pulse cycle.
   AST_EXTRA_CLK0: assert property (@(posedge clk) disable iff (!rst_b)
      (pulseCnt == 6'h3f && $stable(fine) && fine_hit(frameCyc + 4'h1, fine[3:0]))
      |-> active[0]) else $error("extra clock missing on channel 0");
   AST_EXTRA_CLK1: assert property (@(posedge clk) disable iff (!rst_b)
      (pulseCnt == 6'h3f && $stable(fine) && fine_hit(frameCyc + 4'h1, fine[7:4]))
      |-> active[1]) else $error("extra clock missing on channel 1");
   AST_EXTRA_ONE0: assert property (@(posedge clk) disable iff (!rst_b)
      (pulseCnt == 6'h00 && chan[0].weight == 6'h00 && $stable(chan[0]))
      |-> !active[0]) else $error("extra pulse longer than one clock on channel 0");
   AST_EXTRA_ONE1: assert property (@(posedge clk) disable iff (!rst_b)
      (pulseCnt == 6'h00 && chan[1].weight == 6'h00 && $stable(chan[1]))
      |-> !active[1]) else $error("extra pulse longer than one clock on channel 1");

   // Full scale leaves a single inactive clock, just ahead of frame cycle zero.
   AST_FULL_ON0: assert property (@(posedge clk) disable iff (!rst_b)
      (pulseCnt == 6'h3f && frameCyc != 4'hf && chan[0].weight == 6'h3f && fine[3:0] == 4'hf
       && $stable(chan[0]) && $stable(fine))
      |-> active[0]) else $error("full scale gap on channel 0");
   AST_FULL_GAP0: assert property (@(posedge clk) disable iff (!rst_b)
      (counter == 10'h3ff && chan[0].weight == 6'h3f && fine[3:0] == 4'hf
       && $stable(chan[0]) && $stable(fine))
      |-> !active[0]) else $error("full scale has no gap on channel 0");
   AST_FULL_ON1: assert property (@(posedge clk) disable iff (!rst_b)
      (pulseCnt == 6'h3f && frameCyc != 4'hf && chan[1].weight == 6'h3f && fine[7:4] == 4'hf
       && $stable(chan[1]) && $stable(fine))
      |-> active[1]) else $error("full scale gap on channel 1");
   AST_FULL_GAP1: assert property (@(posedge clk) disable iff (!rst_b)
      (counter == 10'h3ff && chan[1].weight == 6'h3f && fine[7:4] == 4'hf
       && $stable(chan[1]) && $stable(fine))
      |-> !active[1]) else $error("full scale has no gap on channel 1");
   AST_FRAME_STEP: assert property (@(posedge clk) disable iff (!rst_b)
      (pulseCnt == 6'h00 && $past(counter[5:0]) == 6'h3f)
      |-> frameCyc == $past(frameCyc) + 4'h1) else $error("frame cycle skipped");

   // Register side: writes land on the completing edge and nowhere else.
   AST_READY_PULSE: assert property (@(posedge clk) disable iff (!rst_b)
      pready |=> !pready) else $error("ready longer than one cycle");
   AST_WRITE_W0: assert property (@(posedge clk) disable iff (!rst_b)
      (busState == prbm_pkg::PRBM_ACCESS && pwrite && paddr == `PRBM_OFS_WEIGHT0)
      |=> chan[0] == $past(pwdata[6:0])) else $error("weight 0 write lost");
   AST_WRITE_W1: assert property (@(posedge clk) disable iff (!rst_b)
      (busState == prbm_pkg::PRBM_ACCESS && pwrite && paddr == `PRBM_OFS_WEIGHT1)
      |=> chan[1] == $past(pwdata[6:0])) else $error("weight 1 write lost");
   AST_WRITE_FINE: assert property (@(posedge clk) disable iff (!rst_b)
      (busState == prbm_pkg::PRBM_ACCESS && pwrite && paddr == `PRBM_OFS_FINE)
      |=> fine == $past(pwdata[7:0])) else $error("fine write lost");
   AST_REGS_HOLD: assert property (@(posedge clk) disable iff (!rst_b)
      !(busState == prbm_pkg::PRBM_ACCESS && pwrite && reg_hit(paddr))
      |=> $stable(chan[0]) && $stable(chan[1]) && $stable(fine))
      else $error("register changed without a write");
   AST_SLVERR: assert property (@(posedge clk) disable iff (!rst_b)
      (busState == prbm_pkg::PRBM_IDLE && psel && !penable)
      |=> pslverr == !$past(reg_hit(paddr))) else $error("error response wrong");
   AST_PRDATA_HOLD: assert property (@(posedge clk) disable iff (!rst_b)
      (busState == prbm_pkg::PRBM_IDLE && !(psel && !penable))
      |=> $stable(prdata)) else $error("read data moved while idle");

endmodule
`default_nettype wire

// file: verilog/prbm_defines.svh
// Register offsets, field positions, reset values and counter widths for the pulse DAC.
// Assumes inclusion by bare name from the package and the design module.
`ifndef PRBM_DEFINES_SVH
`define PRBM_DEFINES_SVH
`define PRBM_OFS_WEIGHT0   12'h000
`define PRBM_OFS_FINE      12'h004
`define PRBM_OFS_WEIGHT1   12'h008
`define PRBM_WEIGHT_RST    8'h80
`define PRBM_FINE_RST      8'h00
`define PRBM_WEIGHT_FIXED  8'h80
`define PRBM_INV_BIT       6
`define PRBM_CNT_W         10
`define PRBM_PULSE_W       6
`define PRBM_FINE_W        4
`endif

// file: verilog/prbm_pkg.sv
// Types shared by the pulse DAC design.
// Assumes the defines header is on the include path.
`include "prbm_defines.svh"
package prbm_pkg;
   typedef struct packed {
      logic       invert;
      logic [5:0] weight;
   } prbm_chan_s;
   typedef enum logic [1:0] {
      PRBM_IDLE   = 2'b01,
      PRBM_ACCESS = 2'b10
   } prbm_bus_e;
endpackage
